// ### rtl/urr_cfg.svh
// register offsets, field positions, reset values and sizes of the endpoint request router
`ifndef URR_CFG_SVH
`define URR_CFG_SVH
`define URR_OFS_ROUTE_SEL     12'h000
`define URR_OFS_MONITOR       12'h004
`define URR_OFS_IRQ_STATUS    12'h008
`define URR_OFS_IRQ_ENABLE    12'h00C
`define URR_OFS_IRQ_CLEAR     12'h010
`define URR_ROUTE_SEL_RESET   32'h0000_0000
`define URR_IRQ_ENABLE_RESET  5'h00
`define URR_BIT_EP_ONE        0
`define URR_BIT_EP_TWO        1
`define URR_BIT_EP_THREE      2
`define URR_BIT_EP_FOUR       3
`define URR_BIT_EP_FIVE       4
`define URR_NUM_SRC           5
`define URR_SYNC_STAGES       3
`endif

// ### rtl/urr_pkg.sv
// types shared by the endpoint request router files
package urr_pkg;
  typedef logic [4:0]  urr_src_vec_t;
  typedef logic [31:0] urr_word_t;
  typedef enum logic [1:0] {
    URR_APB_IDLE   = 2'b00,
    URR_APB_SETUP  = 2'b01,
    URR_APB_ACCESS = 2'b10
  } urr_apb_phase_t;
endpackage

// ### rtl/urr_sync.sv
// three-stage synchroniser for the endpoint request inputs
`timescale 1ns/100ps
`include "urr_cfg.svh"
module urr_sync #(
  parameter int WIDTH = 5
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1_reg;
  logic [WIDTH-1:0] stage2_reg;
  logic [WIDTH-1:0] stage3_reg;
  logic [WIDTH-1:0] held_reg;
  logic [WIDTH-1:0] agree;

  // a change counts only once stages two and three agree
  assign agree = ~(stage2_reg ^ stage3_reg);

  // stage one is read by stage two alone, to keep metastability contained
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage1_reg <= '0;
      stage2_reg <= '0;
      stage3_reg <= '0;
      held_reg   <= '0;
    end else begin
      stage1_reg <= async_in;
      stage2_reg <= stage1_reg;
      stage3_reg <= stage2_reg;
      held_reg   <= (agree & stage3_reg) | (~agree & held_reg);
    end
  end

  assign sync_out = held_reg;
endmodule

// ### rtl/urr_route.sv
// per-source router between the cpu interrupt path and the dma request path
`timescale 1ns/100ps
`include "urr_cfg.svh"
module urr_route #(
  parameter int WIDTH = 5
) (
  input  wire logic [WIDTH-1:0] endpoint_data_request,
  input  wire logic [WIDTH-1:0] route_sel,
  output logic      [WIDTH-1:0] cpu_req,
  output logic      [WIDTH-1:0] dma_req
);
  // a source reaches exactly one side; the other sees zero
  assign cpu_req = endpoint_data_request & ~route_sel;
  // only sources selected for dma can start a hardware transfer
  assign dma_req = endpoint_data_request & route_sel;
endmodule

// ### rtl/urr_router.sv
// top of the usb endpoint data request router with its apb register file
// Behaviour
// - bit 4 sends endpoint five request to cpu at 0, to dma at 1
// - bit 3 sends endpoint four request to cpu at 0, to dma at 1
// - bit 2 sends endpoint three request to cpu at 0, to dma at 1
// - bit 1 sends endpoint two request to cpu at 0, to dma at 1
// - bit 0 sends endpoint one request to cpu at 0, to dma at 1
// - a dma-routed source reads zero in the vector monitor register
// - only dma-routed sources may start hardware dma transfers
`timescale 1ns/100ps
`include "urr_cfg.svh"
module urr_router #(
  parameter int NUM_SRC = `URR_NUM_SRC
) (
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [11:0]        paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire logic [NUM_SRC-1:0] endpoint_data_request,
  output logic      [NUM_SRC-1:0] cpu_irq_req,
  output logic      [NUM_SRC-1:0] dma_xfer_req,
  output logic                    irq
);
  logic [NUM_SRC-1:0] dma_request_route_select_reg;
  logic [NUM_SRC-1:0] irq_status_reg;
  logic [NUM_SRC-1:0] irq_status_next;
  logic [NUM_SRC-1:0] irq_enable_reg;
  logic [NUM_SRC-1:0] req_sync;
  logic [NUM_SRC-1:0] req_prev_reg;
  logic [NUM_SRC-1:0] cpu_comb;
  logic [NUM_SRC-1:0] dma_comb;
  logic [NUM_SRC-1:0] clear_mask;
  logic [31:0]        prdata_next;
  logic               pslverr_next;
  logic               setup_phase;
  logic               hit_route;
  logic               hit_monitor;
  logic               hit_status;
  logic               hit_enable;
  logic               hit_clear;
  logic               hit_any;
  logic               wr_route;
  logic               wr_enable;
  logic               wr_clear;
  urr_pkg::urr_apb_phase_t apb_phase;
  urr_pkg::urr_apb_phase_t apb_phase_reg;

  // reset word of the routing register, cut to the sources that exist
  localparam logic [31:0] ROUTE_RESET_WORD = `URR_ROUTE_SEL_RESET;

  // one register word matches when the byte address equals its offset
  function automatic logic urr_hit(input logic [11:0] addr, input logic [11:0] ofs);
    return (addr == ofs);
  endfunction

  // a write lands only at the edge that ends an answered access phase
  function automatic logic urr_commit(input logic sel, input logic en, input logic rdy, input logic wr,
                                      input logic hit);
    return sel & en & rdy & wr & hit;
  endfunction

  // pins from the usb function block come from outside this clock domain
  urr_sync #(
    .WIDTH    (NUM_SRC)
  ) u_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (endpoint_data_request),
    .sync_out (req_sync)
  );

  // steer each synchronised request to one side only
  urr_route #(
    .WIDTH                 (NUM_SRC)
  ) u_route (
    .endpoint_data_request (req_sync),
    .route_sel             (dma_request_route_select_reg),
    .cpu_req               (cpu_comb),
    .dma_req               (dma_comb)
  );

  // bus phase of this cycle as the slave sees it; enable without select counts as idle
  always_comb begin
    apb_phase = urr_pkg::URR_APB_IDLE;
    case ({psel, penable})
      2'b10: begin
        apb_phase = urr_pkg::URR_APB_SETUP;
      end
      2'b11: begin
        apb_phase = urr_pkg::URR_APB_ACCESS;
      end
      default: begin
        apb_phase = urr_pkg::URR_APB_IDLE;
      end
    endcase
  end

  // zero-wait slave: setup cycle decides, access cycle completes at once
  assign setup_phase = (apb_phase == urr_pkg::URR_APB_SETUP);
  assign hit_route   = urr_hit(paddr, `URR_OFS_ROUTE_SEL);
  assign hit_monitor = urr_hit(paddr, `URR_OFS_MONITOR);
  assign hit_status  = urr_hit(paddr, `URR_OFS_IRQ_STATUS);
  assign hit_enable  = urr_hit(paddr, `URR_OFS_IRQ_ENABLE);
  assign hit_clear   = urr_hit(paddr, `URR_OFS_IRQ_CLEAR);
  assign hit_any     = hit_route | hit_monitor | hit_status | hit_enable | hit_clear;

  // writes take effect at the edge that ends the access phase
  assign wr_route  = urr_commit(psel, penable, pready, pwrite, hit_route);
  assign wr_enable = urr_commit(psel, penable, pready, pwrite, hit_enable);
  assign wr_clear  = urr_commit(psel, penable, pready, pwrite, hit_clear);

  // read mux; monitor bits of dma-routed sources read zero
  always_comb begin
    prdata_next = 32'h0000_0000;
    if (hit_route) begin
      prdata_next[NUM_SRC-1:0] = dma_request_route_select_reg;
    end else if (hit_monitor) begin
      prdata_next[NUM_SRC-1:0] = req_sync & ~dma_request_route_select_reg;
    end else if (hit_status) begin
      prdata_next[NUM_SRC-1:0] = irq_status_reg;
    end else if (hit_enable) begin
      prdata_next[NUM_SRC-1:0] = irq_enable_reg;
    end
  end

  // unmapped addresses and writes to read-only words answer with an error
  assign pslverr_next = ~hit_any | (pwrite & (hit_monitor | hit_status));

  // a rising cpu-side request is the event; set wins over a same-cycle clear
  assign clear_mask      = wr_clear ? pwdata[NUM_SRC-1:0] : '0;
  assign irq_status_next = (irq_status_reg & ~clear_mask) | (cpu_comb & ~req_prev_reg);

  // apb response registers; the last phase is kept so an answer can be matched to its setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      apb_phase_reg <= urr_pkg::URR_APB_IDLE;
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      apb_phase_reg <= apb_phase;
      pready  <= setup_phase;
      pslverr <= setup_phase & pslverr_next;
      prdata  <= (setup_phase & ~pwrite) ? prdata_next : 32'h0000_0000;
    end
  end

  // routing selection; software must first quiet the peripherals
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dma_request_route_select_reg <= ROUTE_RESET_WORD[NUM_SRC-1:0];
    end else if (wr_route) begin
      dma_request_route_select_reg <= pwdata[NUM_SRC-1:0];
    end
  end

  // interrupt enable and sticky status
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_enable_reg <= `URR_IRQ_ENABLE_RESET;
      irq_status_reg <= '0;
      req_prev_reg   <= '0;
    end else begin
      if (wr_enable) begin
        irq_enable_reg <= pwdata[NUM_SRC-1:0];
      end
      irq_status_reg <= irq_status_next;
      req_prev_reg   <= cpu_comb;
    end
  end

  // registered outputs toward cpu interrupt and dma controllers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_irq_req  <= '0;
      dma_xfer_req <= '0;
      irq          <= 1'b0;
    end else begin
      cpu_irq_req  <= cpu_comb;
      dma_xfer_req <= dma_comb;
      irq          <= |(irq_status_next & irq_enable_reg);
    end
  end

  a_out_exclusive: assert property (@(posedge pclk) disable iff (!presetn)
    (cpu_irq_req & dma_xfer_req) == '0)
    else $error("cpu and dma requests active together");

  a_dma_only_selected: assert property (@(posedge pclk) disable iff (!presetn)
    (dma_xfer_req & ~$past(dma_request_route_select_reg)) == '0)
    else $error("dma request from a source not routed to dma");

  a_cpu_ep5_route: assert property (@(posedge pclk) disable iff (!presetn)
    (req_sync[`URR_BIT_EP_FIVE] && !dma_request_route_select_reg[`URR_BIT_EP_FIVE])
    |=> cpu_irq_req[`URR_BIT_EP_FIVE])
    else $error("endpoint five request not delivered to cpu");

  a_dma_ep4_route: assert property (@(posedge pclk) disable iff (!presetn)
    (req_sync[`URR_BIT_EP_FOUR] && dma_request_route_select_reg[`URR_BIT_EP_FOUR])
    |=> dma_xfer_req[`URR_BIT_EP_FOUR] && !cpu_irq_req[`URR_BIT_EP_FOUR])
    else $error("endpoint four request not delivered to dma");

  a_dma_ep3_route: assert property (@(posedge pclk) disable iff (!presetn)
    (req_sync[`URR_BIT_EP_THREE] && dma_request_route_select_reg[`URR_BIT_EP_THREE])
    |=> dma_xfer_req[`URR_BIT_EP_THREE])
    else $error("endpoint three request not delivered to dma");

  a_cpu_ep2_route: assert property (@(posedge pclk) disable iff (!presetn)
    (req_sync[`URR_BIT_EP_TWO] && !dma_request_route_select_reg[`URR_BIT_EP_TWO])
    |=> cpu_irq_req[`URR_BIT_EP_TWO] && !dma_xfer_req[`URR_BIT_EP_TWO])
    else $error("endpoint two request not delivered to cpu");

  a_idle_ep1_quiet: assert property (@(posedge pclk) disable iff (!presetn)
    !req_sync[`URR_BIT_EP_ONE] |=> !cpu_irq_req[`URR_BIT_EP_ONE] && !dma_xfer_req[`URR_BIT_EP_ONE])
    else $error("endpoint one output without request");

  a_monitor_masked: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable && !pwrite && hit_monitor)
    |=> (prdata[NUM_SRC-1:0] & $past(dma_request_route_select_reg)) == '0)
    else $error("monitor shows a dma-routed source");

  a_apb_one_wait: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable) |=> pready)
    else $error("apb access not answered in one cycle");

  // routing from the opposite setting of selection bits 4 to 1, and both settings of bit 0
  a_dma_ep5_route: assert property (@(posedge pclk) disable iff (!presetn)
    (req_sync[`URR_BIT_EP_FIVE] && dma_request_route_select_reg[`URR_BIT_EP_FIVE])
    |=> dma_xfer_req[`URR_BIT_EP_FIVE] && !cpu_irq_req[`URR_BIT_EP_FIVE])
    else $error("endpoint five request not delivered to dma");

  a_cpu_ep4_route: assert property (@(posedge pclk) disable iff (!presetn)
    (req_sync[`URR_BIT_EP_FOUR] && !dma_request_route_select_reg[`URR_BIT_EP_FOUR])
    |=> cpu_irq_req[`URR_BIT_EP_FOUR] && !dma_xfer_req[`URR_BIT_EP_FOUR])
    else $error("endpoint four request not delivered to cpu");

  a_cpu_ep3_route: assert property (@(posedge pclk) disable iff (!presetn)
    (req_sync[`URR_BIT_EP_THREE] && !dma_request_route_select_reg[`URR_BIT_EP_THREE])
    |=> cpu_irq_req[`URR_BIT_EP_THREE] && !dma_xfer_req[`URR_BIT_EP_THREE])
    else $error("endpoint three request not delivered to cpu");

  a_dma_ep2_route: assert property (@(posedge pclk) disable iff (!presetn)
    (req_sync[`URR_BIT_EP_TWO] && dma_request_route_select_reg[`URR_BIT_EP_TWO])
    |=> dma_xfer_req[`URR_BIT_EP_TWO] && !cpu_irq_req[`URR_BIT_EP_TWO])
    else $error("endpoint two request not delivered to dma");

  a_cpu_ep1_route: assert property (@(posedge pclk) disable iff (!presetn)
    (req_sync[`URR_BIT_EP_ONE] && !dma_request_route_select_reg[`URR_BIT_EP_ONE])
    |=> cpu_irq_req[`URR_BIT_EP_ONE] && !dma_xfer_req[`URR_BIT_EP_ONE])
    else $error("endpoint one request not delivered to cpu");

  a_dma_ep1_route: assert property (@(posedge pclk) disable iff (!presetn)
    (req_sync[`URR_BIT_EP_ONE] && dma_request_route_select_reg[`URR_BIT_EP_ONE])
    |=> dma_xfer_req[`URR_BIT_EP_ONE] && !cpu_irq_req[`URR_BIT_EP_ONE])
    else $error("endpoint one request not delivered to dma");

  // no dma request may rise without a synchronised request behind it, and no cpu request from a dma-routed source
  a_dma_needs_request: assert property (@(posedge pclk) disable iff (!presetn)
    (dma_xfer_req & ~$past(req_sync)) == '0)
    else $error("dma request without a source request");

  a_cpu_not_routed: assert property (@(posedge pclk) disable iff (!presetn)
    (cpu_irq_req & $past(dma_request_route_select_reg)) == '0)
    else $error("cpu request from a dma-routed source");

  // a rising request must survive a clear written in the same cycle
  a_status_set_wins: assert property (@(posedge pclk) disable iff (!presetn)
    (irq_status_reg & $past(cpu_comb) & ~$past(req_prev_reg)) == ($past(cpu_comb) & ~$past(req_prev_reg)))
    else $error("status event lost");

  a_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
    irq == |(irq_status_reg & $past(irq_enable_reg)))
    else $error("interrupt line does not follow enabled status");

  // bus answer shape
  a_err_with_ready: assert property (@(posedge pclk) disable iff (!presetn)
    pslverr |-> pready)
    else $error("error response outside an access phase");

  a_rdata_idle_zero: assert property (@(posedge pclk) disable iff (!presetn)
    !pready |-> prdata == 32'h0000_0000)
    else $error("read data driven outside an access phase");

  a_clear_reads_zero: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable && !pwrite && hit_clear) |=> prdata == 32'h0000_0000 && !pslverr)
    else $error("clear word read is not a quiet zero");

  a_ready_after_setup: assert property (@(posedge pclk) disable iff (!presetn)
    pready == (apb_phase_reg == urr_pkg::URR_APB_SETUP))
    else $error("bus answer not tied to a setup cycle");

  // the routing word moves only by a landed write
  a_route_write_lands: assert property (@(posedge pclk) disable iff (!presetn)
    wr_route |=> dma_request_route_select_reg == NUM_SRC'($past(pwdata)))
    else $error("routing write did not land");

  a_route_holds: assert property (@(posedge pclk) disable iff (!presetn)
    !wr_route |=> $stable(dma_request_route_select_reg))
    else $error("routing changed without a write");
endmodule

// ### test/urr_far_side.sv
// behavioural cpu interrupt controller and dma controller seen by the router
`timescale 1ns/100ps
module urr_far_side (
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire urr_pkg::urr_src_vec_t route,
  input  wire urr_pkg::urr_src_vec_t cpu_irq_req,
  input  wire urr_pkg::urr_src_vec_t dma_xfer_req,
  output urr_pkg::urr_src_vec_t      dma_started,
  output logic                       bad_start
);
  urr_pkg::urr_src_vec_t dma_prev;
  // dma starts on a request edge; a start from a cpu-routed source is flagged, never taken
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dma_prev    <= 5'h0_0;
      dma_started <= 5'h0_0;
      bad_start   <= 1'b0;
    end else begin
      dma_prev    <= dma_xfer_req;
      dma_started <= dma_started | (dma_xfer_req & ~dma_prev & route);
      if ((dma_xfer_req & ~route) != 5'h0_0 || (cpu_irq_req & dma_xfer_req) != 5'h0_0) begin
        bad_start <= 1'b1;
      end
    end
  end
endmodule

// ### test/usb_endpoint_request_router_tb_top.sv
// self-checking bench for the endpoint request router
`timescale 1ns/100ps
`include "urr_cfg.svh"
module usb_endpoint_request_router_tb_top;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic pready, pslverr, irq, bad_start, er;
  urr_pkg::urr_src_vec_t req = 5'h0_0, route = 5'h0_0, cpu_irq_req, dma_xfer_req, dma_started;
  int err_count = 0, compares = 0;
  typedef struct {logic [4:0] rt, rq, cpu, dma;} urr_row_t;
  urr_row_t rows [5] = '{'{5'h00,5'h1F,5'h1F,5'h00}, '{5'h1F,5'h1F,5'h00,5'h1F},
    '{5'h15,5'h1F,5'h0A,5'h15}, '{5'h0A,5'h0F,5'h05,5'h0A}, '{5'h10,5'h11,5'h01,5'h10}};
  always #25 pclk = ~pclk;
  urr_router u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .endpoint_data_request(req), .cpu_irq_req(cpu_irq_req), .dma_xfer_req(dma_xfer_req), .irq(irq));
  urr_far_side u_far (.pclk(pclk), .presetn(presetn), .route(route), .cpu_irq_req(cpu_irq_req),
    .dma_xfer_req(dma_xfer_req), .dma_started(dma_started), .bad_start(bad_start));
  // one apb transfer; held until pready is sampled high
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin @(posedge pclk); end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task settle(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task report_and_stop;
    $display("errors %0d compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    #250000;
    err_count++;
    report_and_stop();
  end
  initial begin
    settle(5);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, `URR_OFS_ROUTE_SEL, 32'h0); chk("route reset", `URR_ROUTE_SEL_RESET, rd);
    chk("route read err", 1'b0, er);
    apb(1'b0, `URR_OFS_IRQ_ENABLE, 32'h0); chk("enable reset", 32'h0, rd);
    // table rows: pending requests dropped before every routing change
    foreach (rows[i]) begin
      req <= 5'h0_0;
      settle(8);
      apb(1'b1, `URR_OFS_ROUTE_SEL, {27'h0, rows[i].rt});
      route <= rows[i].rt;
      settle(4);
      req <= rows[i].rq;
      settle(8);
      chk("cpu", rows[i].cpu, cpu_irq_req);
      chk("dma", rows[i].dma, dma_xfer_req);
      chk("exclusive", 5'h0, cpu_irq_req & dma_xfer_req);
      apb(1'b0, `URR_OFS_MONITOR, 32'h0); chk("monitor", {27'h0, rows[i].cpu}, rd);
      chk("irq masked", 1'b0, irq);
    end
    chk("dma starts", 5'h1F, dma_started);
    chk("bad start", 1'b0, bad_start);
    // refusals: unmapped place and read-only monitor and status
    apb(1'b0, 12'h014, 32'h0); chk("unmapped err", 1'b1, er); chk("unmapped data", 32'h0, rd);
    apb(1'b1, `URR_OFS_MONITOR, 32'hFFFF_FFFF); chk("ro write err", 1'b1, er);
    apb(1'b1, `URR_OFS_IRQ_STATUS, 32'h0); chk("status write err", 1'b1, er);
    apb(1'b1, 12'h014, 32'h0000_001F); chk("unmapped wr err", 1'b1, er);
    apb(1'b0, `URR_OFS_ROUTE_SEL, 32'h0); chk("route kept", {27'h0, rows[4].rt}, rd);
    apb(1'b0, `URR_OFS_IRQ_CLEAR, 32'h0); chk("clear read", 32'h0, rd);
    chk("clear read err", 1'b0, er);
    // interrupt: raise masked, enable, clear
    req <= 5'h0_0;
    settle(8);
    apb(1'b1, `URR_OFS_ROUTE_SEL, 32'h0);
    route <= 5'h0_0;
    apb(1'b1, `URR_OFS_IRQ_CLEAR, 32'h0000_001F);
    apb(1'b0, `URR_OFS_IRQ_STATUS, 32'h0); chk("status clear", 32'h0, rd);
    req <= 5'h0_4;
    settle(8);
    apb(1'b0, `URR_OFS_IRQ_STATUS, 32'h0); chk("status set", 32'h0000_0004, rd);
    chk("irq off", 1'b0, irq);
    apb(1'b1, `URR_OFS_IRQ_ENABLE, 32'h0000_0004);
    settle(2);
    chk("irq on", 1'b1, irq);
    req <= 5'h0_0;
    settle(8);
    apb(1'b1, `URR_OFS_IRQ_CLEAR, 32'h0000_0004);
    settle(2);
    chk("irq cleared", 1'b0, irq);
    apb(1'b0, `URR_OFS_IRQ_STATUS, 32'h0); chk("status end", 32'h0, rd);
    // mid-run reset with routing, enables and requests all active
    apb(1'b1, `URR_OFS_ROUTE_SEL, 32'h0000_0015);
    route <= 5'h15;
    apb(1'b1, `URR_OFS_IRQ_ENABLE, 32'h0000_001F);
    req <= 5'h1F;
    settle(8);
    chk("dma pre reset", 5'h15, dma_xfer_req);
    chk("irq pre reset", 1'b1, irq);
    presetn <= 1'b0;
    route <= 5'h00;
    @(posedge pclk);
    chk("cpu in reset", 5'h00, cpu_irq_req);
    chk("dma in reset", 5'h00, dma_xfer_req);
    chk("irq in reset", 1'b0, irq);
    settle(2);
    presetn <= 1'b1;
    @(posedge pclk);
    chk("dma after reset", 5'h00, dma_xfer_req);
    @(posedge pclk);
    chk("cpu after reset", 5'h00, cpu_irq_req);
    apb(1'b0, `URR_OFS_ROUTE_SEL, 32'h0); chk("route after reset", `URR_ROUTE_SEL_RESET, rd);
    apb(1'b0, `URR_OFS_IRQ_ENABLE, 32'h0); chk("enable after reset", 32'h0, rd);
    settle(4);
    chk("cpu refilled", 5'h1F, cpu_irq_req);
    chk("dma refilled", 5'h00, dma_xfer_req);
    chk("irq after reset", 1'b0, irq);
    apb(1'b0, `URR_OFS_IRQ_STATUS, 32'h0); chk("status after reset", 32'h0000_001F, rd);
    chk("bad start end", 1'b0, bad_start);
    report_and_stop();
  end
endmodule
